// ==== pkg/fifo_host_consts.svh ====
// constants for the asynchronous fifo host controller
// assumes a 100 mhz hclk and a word-wide ahb-lite register window
`ifndef FIFO_HOST_CONSTS_SVH
`define FIFO_HOST_CONSTS_SVH
// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_WDATA 12'h004
`define OFF_RDATA 12'h008
`define OFF_STATUS 12'h00C
// ctrl fields
`define CTRL_RESET_BIT 0
`define CTRL_REPLAY_BIT 1
`define CTRL_HEAD_BIT 2
`define CTRL_CASCADE_BIT 3
`define CTRL_RESET_VAL 32'h0000_0000
// timing in ns and derived cycles at 10 ns
`define CLK_NS 10
`define STROBE_LOW_NS 80
`define STROBE_HIGH_NS 40
`define CLEAR_LOW_NS 100
`define SETTLE_NS 100
`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define STROBE_LOW_CYC 8'(`CYC_UP(`STROBE_LOW_NS))
`define STROBE_HIGH_CYC 8'(`CYC_UP(`STROBE_HIGH_NS))
`define CLEAR_LOW_CYC 8'(`CYC_UP(`CLEAR_LOW_NS))
`define SETTLE_CYC 8'(`CYC_UP(`SETTLE_NS))
`endif

// ==== pkg/fifo_host_pkg.sv ====
// types for the asynchronous fifo host controller
// assumes nothing beyond the constants header
package fifo_host_pkg;
	// sequencer states, gray along idle->low->high->settle->idle
	typedef enum logic [2:0]
	{
		st_idle = 3'b000,
		st_low = 3'b001,
		st_high = 3'b011,
		st_settle = 3'b010,
		st_clear = 3'b110
	} seq_state_t;
	// operation kinds
	typedef enum logic [1:0]
	{
		op_write = 2'b00,
		op_read = 2'b01,
		op_clear = 2'b10,
		op_replay = 2'b11
	} op_kind_t;
endpackage

// ==== core/sync2.sv ====
// two-flop synchroniser for a bundle of pin inputs
// assumes pins change asynchronously to hclk
`timescale 1ns/1ps
module sync2
#(
	parameter int W = 1
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// async in, synced out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_ff; // first stage, read only by second
	////////////////////////////////////////////////////////////////
	// both stages reset to all ones (inactive flags)
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta_ff <= '1;
			sync_out <= '1;
		end
		else
		begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule

// ==== core/fifo_host.sv ====
// host controller that drives an asynchronous 9-bit fifo through its pins
// assumes an ahb-lite master on hclk and a fifo whose flags arrive async
// Overview of operation
// - write and read strobes high at clear release
// - cascade_in_n low means standalone device
// - chain head select low on first device
// - cascade out wires to next cascade in
// - composite flags are OR of device flags
// - width devices share controls, any flag valid
// - write strobe only pulsed while not full
// - writer watches full, reader watches empty
// - two buffers pair for two-way traffic
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "fifo_host_consts.svh"
module fifo_host
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// fifo pins; one buffer per instance, two instances pair for two-way
	output logic [8:0] fifo_din,
	input wire logic [8:0] fifo_dout,
	output logic write_n,
	output logic read_n,
	output logic master_clear_n,
	output logic replay_n,
	output logic chain_head_select_n,
	output logic cascade_in_n,
	input wire logic empty_indicator_n,
	input wire logic full_indicator_n,
	input wire logic half_level_indicator_n
);
	////////////////////////////////////////////////////////////////
	// declarations
	logic [11:0] pins_s; // synced {data, half, full, empty}
	logic [8:0] dout_s; // synced read data, stable long before it is sampled
	logic empty_s; // synced empty, low = empty
	logic full_s; // synced full, low = full
	logic half_s; // synced half level, low = over half
	logic [31:0] ctrl_ff; // control register
	logic [8:0] rdata_ff; // last word read
	logic busy_ff; // sequence in progress
	logic refused_ff; // sticky: op refused by guard flag or by cascade mode
	logic flags_valid_ff; // flags trusted
	logic [7:0] cnt_ff; // phase counter
	fifo_host_pkg::seq_state_t state_ff;
	fifo_host_pkg::op_kind_t op_ff;
	logic ap_valid_ff; // pending data phase
	logic ap_write_ff;
	logic [11:0] ap_addr_ff;
	logic [8:0] nxt_din;
	logic go; // write data phase starts an op
	fifo_host_pkg::op_kind_t go_op;
	logic go_ok;
	logic cascade_mode;
	assign empty_s = pins_s[0];
	assign full_s = pins_s[1];
	assign half_s = pins_s[2];
	assign dout_s = pins_s[11:3];
	assign cascade_mode = ctrl_ff[`CTRL_CASCADE_BIT];
	// flags and read data come from another timing world, so two flops first
	sync2 #(.W(12)) u_flag_sync
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({fifo_dout, half_level_indicator_n, full_indicator_n, empty_indicator_n}),
		.sync_out(pins_s)
	);
	////////////////////////////////////////////////////////////////
	// ahb address phase capture; always zero wait
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_valid_ff <= 1'b0;
			ap_write_ff <= 1'b0;
			ap_addr_ff <= 12'h000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			ap_valid_ff <= hsel && htrans[1] && hsize == 3'h2; // whole words only
			ap_write_ff <= hwrite;
			ap_addr_ff <= haddr;
			hreadyout <= 1'b1; // zero wait, every transfer answered at once
			hresp <= 1'b0; // always okay
		end
	end
	// data phase write that launches a pin sequence
	always_comb
	begin
		go = 1'b0;
		go_op = fifo_host_pkg::op_write;
		nxt_din = fifo_din;
		if (ap_valid_ff && ap_write_ff && !busy_ff)
		begin
			case (ap_addr_ff)
				`OFF_WDATA:
				begin
					go = 1'b1;
					nxt_din = hwdata[8:0];
				end
				`OFF_RDATA:
				begin
					go = 1'b1;
					go_op = fifo_host_pkg::op_read;
				end
				`OFF_CTRL:
				begin
					go = hwdata[`CTRL_RESET_BIT] | hwdata[`CTRL_REPLAY_BIT];
					go_op = hwdata[`CTRL_RESET_BIT] ? fifo_host_pkg::op_clear
						: fifo_host_pkg::op_replay;
				end
				default: go = 1'b0;
			endcase
		end
	end

	// guard flags decide whether a write or read strobe may be issued; replay needs standalone mode, clear always goes
	always_comb
	begin
		case (go_op)
			fifo_host_pkg::op_write: go_ok = full_s && flags_valid_ff;
			fifo_host_pkg::op_read: go_ok = empty_s && flags_valid_ff;
			fifo_host_pkg::op_replay: go_ok = !cascade_mode;
			default: go_ok = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// control register: mode bits only, action bits self clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_ff <= `CTRL_RESET_VAL;
		else if (ap_valid_ff && ap_write_ff && ap_addr_ff == `OFF_CTRL && !busy_ff)
			ctrl_ff <= {28'h000_0000, hwdata[3:2], 2'b00};
	end

	// mode pins follow control: standalone, or cascade head/non-head
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cascade_in_n <= 1'b0;
			chain_head_select_n <= 1'b1;
		end
		else
		begin
			cascade_in_n <= cascade_mode; // low only when standalone
			chain_head_select_n <= cascade_mode ? ctrl_ff[`CTRL_HEAD_BIT] : 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// pin sequencer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= fifo_host_pkg::st_idle;
			op_ff <= fifo_host_pkg::op_write;
			cnt_ff <= 8'h00;
			busy_ff <= 1'b0;
			write_n <= 1'b1;
			read_n <= 1'b1;
			master_clear_n <= 1'b1;
			replay_n <= 1'b1;
			fifo_din <= 9'h000;
			rdata_ff <= 9'h000;
			refused_ff <= 1'b0;
			flags_valid_ff <= 1'b0;
		end
		else
		begin
			case (state_ff)
				fifo_host_pkg::st_idle:
				begin
					if (go && go_ok)
					begin
						op_ff <= go_op;
						busy_ff <= 1'b1;
						fifo_din <= nxt_din;
						state_ff <= fifo_host_pkg::st_low;
						if (go_op == fifo_host_pkg::op_clear)
						begin
							cnt_ff <= `CLEAR_LOW_CYC;
							master_clear_n <= 1'b0;
							flags_valid_ff <= 1'b0;
						end
						else
							cnt_ff <= `STROBE_LOW_CYC;
						write_n <= !(go_op == fifo_host_pkg::op_write);
						read_n <= !(go_op == fifo_host_pkg::op_read);
						replay_n <= !(go_op == fifo_host_pkg::op_replay);
					end
					else if (go)
						refused_ff <= 1'b1;
					else if (ap_valid_ff && !ap_write_ff && ap_addr_ff == `OFF_STATUS)
						refused_ff <= 1'b0;
				end
				fifo_host_pkg::st_low:
				begin
					if (cnt_ff > 8'h01)
						cnt_ff <= cnt_ff - 8'h01;
					else
					begin
						// data sampled before read rises; write data held over rise
						if (op_ff == fifo_host_pkg::op_read)
							rdata_ff <= dout_s;
						write_n <= 1'b1;
						read_n <= 1'b1;
						replay_n <= 1'b1;
						master_clear_n <= 1'b1; // strobes already high
						cnt_ff <= `STROBE_HIGH_CYC;
						state_ff <= fifo_host_pkg::st_high;
					end
				end
				fifo_host_pkg::st_high:
				begin
					// recovery gap lets flags settle after the strobe rise
					if (cnt_ff > 8'h01)
						cnt_ff <= cnt_ff - 8'h01;
					else if (op_ff == fifo_host_pkg::op_clear)
					begin
						cnt_ff <= `SETTLE_CYC;
						state_ff <= fifo_host_pkg::st_settle;
					end
					else
					begin
						busy_ff <= 1'b0;
						state_ff <= fifo_host_pkg::st_idle;
					end
				end
				fifo_host_pkg::st_settle:
				begin
					// strobes stay high well after clear release
					if (cnt_ff > 8'h01)
						cnt_ff <= cnt_ff - 8'h01;
					else
					begin
						flags_valid_ff <= 1'b1;
						busy_ff <= 1'b0;
						state_ff <= fifo_host_pkg::st_idle;
					end
				end
				default:
				begin
					state_ff <= fifo_host_pkg::st_idle;
					busy_ff <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux; empty and full reported as seen, half forced high in cascade mode, composite flags are external
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hsel && htrans[1] && !hwrite)
		begin
			case (haddr)
				`OFF_CTRL: hrdata <= ctrl_ff;
				`OFF_RDATA: hrdata <= {23'h00_0000, rdata_ff};
				`OFF_STATUS: hrdata <= {26'h000_0000, refused_ff, flags_valid_ff, busy_ff,
					cascade_mode | half_s, full_s, empty_s};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// ==== verif/fifo_host_asserts.sv ====
// checker for the fifo pin protocol of the host controller
// assumes a bind into fifo_host; flags come from the device
`timescale 1ns/1ps
module fifo_host_asserts
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// fifo pins
	input wire logic write_n,
	input wire logic read_n,
	input wire logic master_clear_n,
	input wire logic replay_n,
	input wire logic cascade_in_n,
	input wire logic [8:0] fifo_din,
	input wire logic empty_indicator_n,
	input wire logic full_indicator_n
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////
	chk_clear_quiet: assert property (!master_clear_n |-> write_n && read_n)
		else $error("strobe low during clear");
	chk_clear_width: assert property ($fell(master_clear_n) |-> !master_clear_n [*8])
		else $error("clear pulse short");
	chk_write_guard: assert property ($fell(write_n) |-> full_indicator_n)
		else $error("write while full");
	chk_read_guard: assert property ($fell(read_n) |-> empty_indicator_n)
		else $error("read while empty");
	chk_write_width: assert property ($fell(write_n) |-> !write_n [*7])
		else $error("write pulse short");
	chk_data_hold: assert property (!write_n ##1 !write_n |-> $stable(fifo_din))
		else $error("data moved in write");
	chk_replay_alone: assert property ($fell(replay_n) |-> !cascade_in_n)
		else $error("replay in cascade");
	chk_replay_quiet: assert property (!replay_n |-> write_n && read_n)
		else $error("strobe low in replay");
	// main traffic seen
	cov_write: cover property ($fell(write_n));
	cov_read: cover property ($fell(read_n));
	cov_replay: cover property ($fell(replay_n));
endmodule

// ==== verif/fifo_dev_model.sv ====
// model of the 9-bit asynchronous fifo device
// assumes strobes from fifo_host; depth is chosen by the bench
`timescale 1ns/1ps
module fifo_dev_model
#(
	parameter int DEPTH = 256
)
(
	// strobes from the host
	input wire logic write_n,
	input wire logic read_n,
	input wire logic master_clear_n,
	input wire logic replay_n,
	input wire logic cascade_in_n,
	// data
	input wire logic [8:0] fifo_din,
	output logic [8:0] fifo_dout,
	// flags, active low
	output logic empty_indicator_n,
	output logic full_indicator_n,
	output logic half_level_indicator_n
);
	logic [8:0] mem [DEPTH];
	logic [8:0] word;
	int wp;
	int rp;
	////////////////////////////////
	// clear sends both pointers home
	always @(negedge master_clear_n)
	begin
		wp = 0;
		rp = 0;
	end
	// stored at write rise whenever room exists, also right after a read frees a slot
	always @(posedge write_n)
		if (master_clear_n === 1'b1 && wp - rp < DEPTH)
		begin
			mem[wp % DEPTH] = fifo_din;
			wp++;
		end
	// word out while read low, pointer moves at the rise
	always @(negedge read_n)
		if (wp != rp)
			word = mem[rp % DEPTH];
	always @(posedge read_n)
		if (master_clear_n === 1'b1 && wp != rp)
			rp++;
	// only valid under DEPTH writes since clear
	always @(negedge replay_n)
		if (!cascade_in_n)
			rp = 0;
	// released bus shows the inverse, so stale data cannot pass
	assign fifo_dout = !read_n ? word : ~word;
	assign empty_indicator_n = wp != rp;
	assign full_indicator_n = wp - rp != DEPTH;
	assign half_level_indicator_n = cascade_in_n || wp - rp <= DEPTH / 2;
endmodule

// ==== verif/tb_top.sv ====
// bench: ahb master drives fifo_host against the device model
// assumes one ahb slave and a full 256-word device
`timescale 1ns/1ps
module tb_top;
	localparam int D = 256;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, s;
	logic [8:0] fifo_din, fifo_dout;
	logic write_n, read_n, master_clear_n, replay_n, chain_head_select_n, cascade_in_n;
	logic empty_indicator_n, full_indicator_n, half_level_indicator_n;
	int err_count, samples_checked;
	fifo_host u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hrdata, .hreadyout, .hresp, .fifo_din, .fifo_dout, .write_n, .read_n,
		.master_clear_n, .replay_n, .chain_head_select_n, .cascade_in_n,
		.empty_indicator_n, .full_indicator_n, .half_level_indicator_n);
	fifo_dev_model #(.DEPTH(D)) u_dev (.write_n, .read_n, .master_clear_n, .replay_n,
		.cascade_in_n, .fifo_din, .fifo_dout, .empty_indicator_n, .full_indicator_n,
		.half_level_indicator_n);
	////////////////////////////////
	initial
	begin
		hclk = 0;
		forever #5 hclk = ~hclk;
	end
	// single transfer; result left in s
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		s = hrdata;
		chk("hresp", 9'h000, {8'h00, hresp});
	endtask
	// launch, then poll until idle; s holds status
	task automatic op(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		do
			bus(1'b0, 12'h00C, 32'h0000_0000);
		while (s[3] !== 1'b0);
	endtask
	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] v);
		samples_checked++;
		if (v !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic rd_chk(input logic [8:0] e);
		op(12'h008, 32'h0000_0000);
		bus(1'b0, 12'h008, 32'h0000_0000);
		chk("word", e, s[8:0]);
	endtask
	////////////////////////////////
	task automatic t_clear;
		op(12'h004, 32'h0000_0055);
		chk("refused", 9'h001, {8'h00, s[5]});
		op(12'h000, 32'h0000_0001);
		chk("status", 9'h016, {3'h0, s[5:0]});
		chk("standalone", 9'h000, {8'h00, cascade_in_n});
	endtask
	task automatic t_fill;
		for (int i = 0; i < D; i++)
		begin
			op(12'h004, {23'h0, 9'h155 + 9'(i)});
			chk("half", {8'h00, i < D / 2}, {8'h00, s[2]});
		end
		chk("full", 9'h000, {8'h00, s[1]});
		op(12'h004, 32'h0000_0077);
		chk("refused", 9'h001, {8'h00, s[5]});
	endtask
	task automatic t_drain;
		for (int i = 0; i < D; i++)
			rd_chk(9'h155 + 9'(i));
		bus(1'b0, 12'h00C, 32'h0000_0000);
		chk("status", 9'h016, {3'h0, s[5:0]});
		op(12'h008, 32'h0000_0000);
		chk("refused", 9'h001, {8'h00, s[5]});
	endtask
	task automatic t_replay;
		op(12'h000, 32'h0000_0001);
		op(12'h004, 32'h0000_00AA);
		op(12'h004, 32'h0000_0133);
		rd_chk(9'h0AA);
		op(12'h000, 32'h0000_0002);
		rd_chk(9'h0AA);
		rd_chk(9'h133);
	endtask
	task automatic t_cascade;
		op(12'h000, 32'h0000_0008);
		chk("head", 9'h000, {8'h00, chain_head_select_n});
		chk("cascade", 9'h001, {8'h00, cascade_in_n});
		op(12'h000, 32'h0000_000A);
		chk("refused", 9'h001, {8'h00, s[5]});
		op(12'h000, 32'h0000_0009);
		chk("status", 9'h016, {3'h0, s[5:0]});
	endtask
	task automatic conclude;
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#400000;
		err_count++;
		conclude();
	end
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 12'h000;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		err_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_clear();
		t_fill();
		t_drain();
		t_replay();
		t_cascade();
		conclude();
	end
endmodule
bind fifo_host fifo_host_asserts u_chk (.hclk, .hresetn, .write_n, .read_n, .master_clear_n,
	.replay_n, .cascade_in_n, .fifo_din, .empty_indicator_n, .full_indicator_n);
